// ### include/ssrx_pkg.sv
// constants and types for the secondary receive slot mapper
package ssrx_pkg;
  localparam int          NUM_CH      = 3;
  localparam int          HALF_SLOTS  = 16;
  localparam int          ENABLE_BIT  = 5;
  localparam logic [7:0]  IDX_PIN_SEL = 8'h27;
  localparam logic [7:0]  IDX_CH2     = 8'h29;
  localparam logic [7:0]  IDX_CH3     = 8'h2a;
  localparam logic [7:0]  IDX_CH4     = 8'h2b;
  localparam logic [7:0]  IDX_FORMAT  = 8'h30;
  localparam logic [7:0]  IDX_DATA2   = 8'h31;
  localparam logic [7:0]  IDX_DATA3   = 8'h32;
  localparam logic [7:0]  IDX_DATA4   = 8'h33;
  localparam logic [7:0]  ROUTE2_RST  = 8'h01;
  localparam logic [7:0]  ROUTE3_RST  = 8'h02;
  localparam logic [7:0]  ROUTE4_RST  = 8'h03;
  localparam logic [2:0]  PIN_SEL_RST = 3'h0;
  localparam int          PIN_SEL_LSB = 1;

  typedef struct packed {
    logic [1:0] rsv;
    logic       enable;
    logic [4:0] slot;
  } ssrx_route_t;

  typedef enum logic [1:0] {
    FMT_TDM = 2'h0,
    FMT_I2S = 2'h1,
    FMT_LJUST = 2'h2
  } ssrx_fmt_t;

  localparam ssrx_fmt_t FMT_RST = FMT_TDM;

  typedef struct packed {
    ssrx_route_t [2:0] route;
    logic [2:0]        pin_sel;
    ssrx_fmt_t         fmt;
  } ssrx_cfg_t;

  localparam ssrx_cfg_t CFG_RST = '{route: {ROUTE4_RST, ROUTE3_RST, ROUTE2_RST},
                                    pin_sel: PIN_SEL_RST, fmt: FMT_RST};

  typedef enum logic [1:0] {
    ST_HUNT = 2'b01,
    ST_RUN  = 2'b10
  } ssrx_state_t;
endpackage

// ### design/ssrx_slot_mapper.sv
// secondary serial port receive slot mapper for playback channels 2 to 4
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module ssrx_slot_mapper #(
  parameter int SLOT_BITS = 32
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic [31:0]                      hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  input  wire logic                        bclk,
  input  wire logic                        fsync,
  input  wire logic                        serial_input,
  input  wire logic                        second_serial_input,
  output logic [2:0][SLOT_BITS-1:0]        dac_word,
  output logic [2:0]                       dac_valid
);
  localparam int CW = $clog2(SLOT_BITS);
  initial begin
    if (SLOT_BITS < 2 || SLOT_BITS > 32) begin
      $error("SLOT_BITS must lie between 2 and 32");
    end
  end
  function automatic logic slot_hit(ssrx_pkg::ssrx_route_t r, ssrx_pkg::ssrx_fmt_t f,
                                    logic half, logic [5:0] slot);
    logic hit;
    hit = 1'b0;
    if (f == ssrx_pkg::FMT_TDM) begin
      hit = (slot == {1'b0, r.slot});
    end else begin
      hit = (slot[5:4] == 2'b00) && (slot[3:0] == r.slot[3:0]) && (r.slot[4] == half);
    end
    return hit;
  endfunction
  // link domain state, declared ahead of the bus side that reads it
  logic                                  lrst_s1_reg, lrst_n;
  logic                                  fs_s1_reg, fs_s2_reg, fs_s3_reg;
  logic                                  d0_s1_reg, d0_s2_reg, d1_s1_reg, d1_s2_reg;
  logic                                  rq_s1_reg, rq_s2_reg, ack_l_reg;
  ssrx_pkg::ssrx_cfg_t                   cfg_l_reg, cfg_l_next;
  ssrx_pkg::ssrx_state_t                 state_reg, state_next;
  logic [CW-1:0]                         bit_reg, bit_next, bit_cur;
  logic [5:0]                            slot_reg, slot_next, slot_cur;
  logic                                  half_reg, half_next, half_cur;
  logic                                  pend_reg, pend_next, pend_half_reg, pend_half_next;
  logic [SLOT_BITS-1:0]                  sh0_reg, sh1_reg, word0, word1;
  logic [2:0][SLOT_BITS-1:0]             cap_reg, cap_next;
  logic [2:0]                            ltog_reg, ltog_next;
  logic                                  start, edge_any, word_done;
  // system domain: bus slave and registers
  ssrx_pkg::ssrx_route_t [2:0]           route_reg, route_next;
  logic [2:0]                            pin_sel_reg, pin_sel_next;
  ssrx_pkg::ssrx_fmt_t                   fmt_reg, fmt_next;
  logic                                  dph_wr_reg, dph_wr_next;
  logic [7:0]                            dph_idx_reg, dph_idx_next;
  logic [31:0]                           hrdata_reg, hrdata_next;
  logic                                  hreadyout_reg;
  logic                                  hresp_reg;
  ssrx_pkg::ssrx_cfg_t                   shadow_reg, shadow_next;
  logic                                  req_reg, req_next;
  logic                                  ack_s1_reg, ack_s2_reg;
  logic [2:0]                            tog_s1_reg, tog_s2_reg, tog_s3_reg;
  logic [2:0][SLOT_BITS-1:0]             data_reg, data_next;
  logic [2:0]                            valid_reg, valid_next;
  logic                                  addr_ok;
  logic [7:0]                            a_idx;
  ssrx_pkg::ssrx_cfg_t                   live_cfg;
  assign addr_ok  = hsel && htrans[1] && hready;
  assign a_idx    = haddr[9:2];
  assign live_cfg = '{route: route_reg, pin_sel: pin_sel_reg, fmt: fmt_reg};
  always_comb begin
    route_next   = route_reg;
    pin_sel_next = pin_sel_reg;
    fmt_next     = fmt_reg;
    dph_wr_next  = addr_ok && hwrite;
    dph_idx_next = addr_ok ? a_idx : dph_idx_reg;
    hrdata_next  = 32'h0000_0000;
    shadow_next  = shadow_reg;
    req_next     = req_reg;
    data_next    = data_reg;
    valid_next   = 3'h0;
    if (dph_wr_reg) begin
      if (dph_idx_reg == ssrx_pkg::IDX_CH2) begin
        route_next[0] = {2'b00, hwdata[5:0]};
      end else if (dph_idx_reg == ssrx_pkg::IDX_CH3) begin
        route_next[1] = {2'b00, hwdata[5:0]};
      end else if (dph_idx_reg == ssrx_pkg::IDX_CH4) begin
        route_next[2] = {2'b00, hwdata[5:0]};
      end else if (dph_idx_reg == ssrx_pkg::IDX_PIN_SEL) begin
        pin_sel_next = hwdata[ssrx_pkg::PIN_SEL_LSB +: 3];
      end else if (dph_idx_reg == ssrx_pkg::IDX_FORMAT) begin
        if (hwdata[1:0] != 2'h3) begin
          fmt_next = ssrx_pkg::ssrx_fmt_t'(hwdata[1:0]);
        end
      end
    end
    if (addr_ok && !hwrite) begin
      if (a_idx == ssrx_pkg::IDX_CH2) begin
        hrdata_next = {24'h00_0000, route_reg[0]};
      end else if (a_idx == ssrx_pkg::IDX_CH3) begin
        hrdata_next = {24'h00_0000, route_reg[1]};
      end else if (a_idx == ssrx_pkg::IDX_CH4) begin
        hrdata_next = {24'h00_0000, route_reg[2]};
      end else if (a_idx == ssrx_pkg::IDX_PIN_SEL) begin
        hrdata_next = {28'h000_0000, pin_sel_reg, 1'b0};
      end else if (a_idx == ssrx_pkg::IDX_FORMAT) begin
        hrdata_next = {30'h0000_0000, fmt_reg};
      end else if (a_idx == ssrx_pkg::IDX_DATA2) begin
        hrdata_next = 32'(data_reg[0]);
      end else if (a_idx == ssrx_pkg::IDX_DATA3) begin
        hrdata_next = 32'(data_reg[1]);
      end else if (a_idx == ssrx_pkg::IDX_DATA4) begin
        hrdata_next = 32'(data_reg[2]);
      end
    end
    // configuration handed to the link side only while no crossing is open
    if ((req_reg == ack_s2_reg) && (live_cfg != shadow_reg)) begin
      shadow_next = live_cfg;
      req_next    = ~req_reg;
    end
    for (int i = 0; i < ssrx_pkg::NUM_CH; i++) begin
      if (tog_s2_reg[i] != tog_s3_reg[i]) begin
        data_next[i]  = cap_reg[i];
        valid_next[i] = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      route_reg     <= {ssrx_pkg::ROUTE4_RST, ssrx_pkg::ROUTE3_RST, ssrx_pkg::ROUTE2_RST};
      pin_sel_reg   <= ssrx_pkg::PIN_SEL_RST;
      fmt_reg       <= ssrx_pkg::FMT_RST;
      dph_wr_reg    <= 1'b0;
      dph_idx_reg   <= 8'h00;
      hrdata_reg    <= 32'h0000_0000;
      hreadyout_reg <= 1'b0;
      hresp_reg     <= 1'b0;
      shadow_reg    <= ssrx_pkg::CFG_RST;
      req_reg       <= 1'b0;
      ack_s1_reg    <= 1'b0;
      ack_s2_reg    <= 1'b0;
      tog_s1_reg    <= 3'h0;
      tog_s2_reg    <= 3'h0;
      tog_s3_reg    <= 3'h0;
      data_reg      <= '0;
      valid_reg     <= 3'h0;
    end else begin
      route_reg     <= route_next;
      pin_sel_reg   <= pin_sel_next;
      fmt_reg       <= fmt_next;
      dph_wr_reg    <= dph_wr_next;
      dph_idx_reg   <= dph_idx_next;
      hrdata_reg    <= hrdata_next;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
      shadow_reg    <= shadow_next;
      req_reg       <= req_next;
      ack_s1_reg    <= ack_l_reg;
      ack_s2_reg    <= ack_s1_reg;
      tog_s1_reg    <= ltog_reg;
      tog_s2_reg    <= tog_s1_reg;
      tog_s3_reg    <= tog_s2_reg;
      data_reg      <= data_next;
      valid_reg     <= valid_next;
    end
  end
  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;
  assign dac_word  = data_reg;
  assign dac_valid = valid_reg;
  // link domain: frame tracking and slot capture
  assign edge_any  = fs_s2_reg ^ fs_s3_reg;
  assign word0     = {sh0_reg[SLOT_BITS-2:0], d0_s2_reg};
  assign word1     = {sh1_reg[SLOT_BITS-2:0], d1_s2_reg};
  always_comb begin
    cfg_l_next     = (rq_s2_reg != ack_l_reg) ? shadow_reg : cfg_l_reg;
    pend_next      = 1'b0;
    pend_half_next = pend_half_reg;
    start          = 1'b0;
    half_cur       = half_reg;
    if (cfg_l_reg.fmt == ssrx_pkg::FMT_TDM) begin
      start    = fs_s2_reg && !fs_s3_reg;
      half_cur = 1'b0;
    end else if (cfg_l_reg.fmt == ssrx_pkg::FMT_LJUST) begin
      start = edge_any;
      if (edge_any) begin
        half_cur = !fs_s2_reg;
      end
    end else begin
      start          = pend_reg;
      pend_next      = edge_any;
      pend_half_next = edge_any ? fs_s2_reg : pend_half_reg;
      if (pend_reg) begin
        half_cur = pend_half_reg;
      end
    end
    bit_cur    = start ? '0 : bit_reg;
    slot_cur   = start ? 6'h00 : slot_reg;
    state_next = (start || state_reg == ssrx_pkg::ST_RUN) ? ssrx_pkg::ST_RUN : ssrx_pkg::ST_HUNT;
    word_done  = (state_next == ssrx_pkg::ST_RUN) && (bit_cur == CW'(SLOT_BITS - 1));
    half_next  = half_cur;
    bit_next   = word_done ? '0 : CW'(bit_cur + 1'b1);
    slot_next  = (word_done && slot_cur != 6'h3f) ? 6'(slot_cur + 1'b1) : slot_cur;
    cap_next   = cap_reg;
    ltog_next  = ltog_reg;
    for (int i = 0; i < ssrx_pkg::NUM_CH; i++) begin
      if (word_done && cfg_l_reg.route[i].enable &&
          slot_hit(cfg_l_reg.route[i], cfg_l_reg.fmt, half_cur, slot_cur)) begin
        cap_next[i]  = cfg_l_reg.pin_sel[i] ? word1 : word0;
        ltog_next[i] = ~ltog_reg[i];
      end
    end
  end
  always_ff @(posedge bclk or negedge rst_n) begin
    if (!rst_n) begin
      lrst_s1_reg <= 1'b0;
      lrst_n      <= 1'b0;
    end else begin
      lrst_s1_reg <= 1'b1;
      lrst_n      <= lrst_s1_reg;
    end
  end
  always_ff @(posedge bclk or negedge lrst_n) begin
    if (!lrst_n) begin
      fs_s1_reg     <= 1'b0;
      fs_s2_reg     <= 1'b0;
      fs_s3_reg     <= 1'b0;
      d0_s1_reg     <= 1'b0;
      d0_s2_reg     <= 1'b0;
      d1_s1_reg     <= 1'b0;
      d1_s2_reg     <= 1'b0;
      rq_s1_reg     <= 1'b0;
      rq_s2_reg     <= 1'b0;
      ack_l_reg     <= 1'b0;
      cfg_l_reg     <= ssrx_pkg::CFG_RST;
      state_reg     <= ssrx_pkg::ST_HUNT;
      bit_reg       <= '0;
      slot_reg      <= 6'h00;
      half_reg      <= 1'b0;
      pend_reg      <= 1'b0;
      pend_half_reg <= 1'b0;
      sh0_reg       <= '0;
      sh1_reg       <= '0;
      cap_reg       <= '0;
      ltog_reg      <= 3'h0;
    end else begin
      fs_s1_reg     <= fsync;
      fs_s2_reg     <= fs_s1_reg;
      fs_s3_reg     <= fs_s2_reg;
      d0_s1_reg     <= serial_input;
      d0_s2_reg     <= d0_s1_reg;
      d1_s1_reg     <= second_serial_input;
      d1_s2_reg     <= d1_s1_reg;
      rq_s1_reg     <= req_reg;
      rq_s2_reg     <= rq_s1_reg;
      ack_l_reg     <= rq_s2_reg;
      cfg_l_reg     <= cfg_l_next;
      state_reg     <= state_next;
      bit_reg       <= bit_next;
      slot_reg      <= slot_next;
      half_reg      <= half_next;
      pend_reg      <= pend_next;
      pend_half_reg <= pend_half_next;
      sh0_reg       <= word0;
      sh1_reg       <= word1;
      cap_reg       <= cap_next;
      ltog_reg      <= ltog_next;
    end
  end
  // checks
  a_rsv_read_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ({route_reg[0].rsv, route_reg[1].rsv, route_reg[2].rsv} == 6'h00 &&
     !(($past(addr_ok) && !$past(hwrite) && $past(a_idx) == ssrx_pkg::IDX_CH2) && hrdata[7:6] != 2'b00)))
    else $error("reserved routing bits not zero");
  a_ch2_enable_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (dph_wr_reg && dph_idx_reg == ssrx_pkg::IDX_CH2) |=> (route_reg[0].enable == $past(hwdata[5])))
    else $error("channel 2 enable not stored");
  a_ch3_gated_capture: assert property (@(posedge bclk) disable iff (!lrst_n)
    (ltog_reg[1] != $past(ltog_reg[1])) |-> $past(cfg_l_reg.route[1].enable))
    else $error("channel 3 captured while disabled");
  a_ch4_gated_capture: assert property (@(posedge bclk) disable iff (!lrst_n)
    !cfg_l_reg.route[2].enable ##1 !cfg_l_reg.route[2].enable |-> $stable(ltog_reg[2]))
    else $error("channel 4 captured while disabled");
  a_tdm_slot_match: assert property (@(posedge bclk) disable iff (!lrst_n)
    (word_done && cfg_l_reg.fmt == ssrx_pkg::FMT_TDM && cfg_l_reg.route[0].enable &&
     slot_cur == {1'b0, cfg_l_reg.route[0].slot}) |=> (ltog_reg[0] != $past(ltog_reg[0])))
    else $error("tdm slot missed");
  a_left_half_slot: assert property (@(posedge bclk) disable iff (!lrst_n)
    ((ltog_reg[0] != $past(ltog_reg[0])) && $past(cfg_l_reg.fmt) != ssrx_pkg::FMT_TDM &&
     !$past(cfg_l_reg.route[0].slot[4])) |-> (!$past(half_cur) &&
     $past(slot_cur) == {2'b00, $past(cfg_l_reg.route[0].slot[3:0])}))
    else $error("left half slot wrong");
  a_right_half_slot: assert property (@(posedge bclk) disable iff (!lrst_n)
    ((ltog_reg[1] != $past(ltog_reg[1])) && $past(cfg_l_reg.fmt) != ssrx_pkg::FMT_TDM &&
     $past(cfg_l_reg.route[1].slot[4])) |-> ($past(half_cur) &&
     $past(slot_cur) == {2'b00, $past(cfg_l_reg.route[1].slot[3:0])}))
    else $error("right half slot wrong");
  a_reset_values: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> (route_reg[0] == 8'h01 && route_reg[1] == 8'h02 && route_reg[2] == 8'h03))
    else $error("routing reset values wrong");
  a_pin_select: assert property (@(posedge bclk) disable iff (!lrst_n)
    (ltog_reg[2] != $past(ltog_reg[2])) |->
    (cap_reg[2] == ($past(cfg_l_reg.pin_sel[2]) ? $past(word1) : $past(word0))))
    else $error("wrong data pin captured");
  a_valid_delivery: assert property (@(posedge clk_sys) disable iff (!rst_n)
    valid_reg[0] |-> (data_reg[0] == cap_reg[0]) ##1 !valid_reg[0])
    else $error("delivered word wrong or pulse too long");
  a_bus_ready: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) |-> (hreadyout && !hresp))
    else $error("bus slave not ready");
  c_tdm_capture: cover property (@(posedge bclk) disable iff (!lrst_n)
    word_done && cfg_l_reg.fmt == ssrx_pkg::FMT_TDM && ltog_next[0] != ltog_reg[0]);
  c_right_capture: cover property (@(posedge bclk) disable iff (!lrst_n)
    word_done && cfg_l_reg.fmt != ssrx_pkg::FMT_TDM && half_cur && ltog_next != ltog_reg);
  c_second_pin: cover property (@(posedge bclk) disable iff (!lrst_n)
    cfg_l_reg.pin_sel[0] && ltog_next[0] != ltog_reg[0]);
  c_delivered: cover property (@(posedge clk_sys) disable iff (!rst_n) valid_reg == 3'h7);
endmodule

`default_nettype wire

// ### sim/ssrx_frame_src.sv
// far-end frame source: bit clock, frame sync and both serial data pins
`timescale 1ns/1ps
`default_nettype none
module ssrx_frame_src #(
  parameter int SB = 16
) (
  output logic bclk,
  output logic fsync,
  output logic din_a,
  output logic din_b
);
  initial begin
    bclk = 1'b0;
    fsync = 1'b0;
    din_a = 1'b0;
    din_b = 1'b1;
  end

  // one frame with lead-in and tail; clock stands still outside
  task automatic send_frame(input logic [1:0]          f,
                            input logic [31:0][SB-1:0] wa,
                            input logic [31:0][SB-1:0] wb);
    int p;
    bit inh;
    #7.3;
    for (int q = -10; q < 32 * SB + 6; q++) begin
      bclk = 1'b0;
      inh = (q >= 0) && (q < 16 * SB);
      // tdm pulse, lj high left half, i2s low left half
      fsync = (f == 2'h0) ? (q == 0) : (f == 2'h2) ? inh : !inh;
      p = (f == 2'h1) ? q - 1 : q;
      // slots 0..15 left half, 16..31 right half
      if (p >= 0 && p < 32 * SB) begin
        din_a = wa[p / SB][SB - 1 - p % SB];
        din_b = wb[p / SB][SB - 1 - p % SB];
      end else begin
        din_a = ~din_a;
        din_b = ~din_b;
      end
      #40;
      bclk = 1'b1;
      #40;
    end
    bclk = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### sim/ssrx_slot_mapper_test.sv
// self-checking bench for the secondary receive slot mapper
`timescale 1ns/1ps
`default_nettype none
module ssrx_slot_mapper_test;
  localparam int SB = 16;
  logic                 clk_sys;
  logic                 rst_n;
  logic                 hsel;
  logic [31:0]          haddr;
  logic [1:0]           htrans;
  logic                 hwrite;
  logic [31:0]          hwdata;
  logic [31:0]          hrdata;
  logic                 hreadyout;
  logic                 hresp;
  logic                 bclk;
  logic                 fsync;
  logic                 din_a;
  logic                 din_b;
  logic [2:0][SB-1:0]   dac_word;
  logic [2:0]           dac_valid;
  int                   errors;
  int                   cmp_count;
  int                   cap_cnt [3] = '{0, 0, 0};
  int                   prev [3];
  logic [SB-1:0]        cap_word [3];
  logic [SB-1:0]        last [3] = '{default: '0};
  logic [31:0]          seed;
  logic [31:0]          rd;
  logic [31:0][SB-1:0]  wa;
  logic [31:0][SB-1:0]  wb;
  logic [2:0]           en;
  logic [2:0]           pin;
  logic [2:0][4:0]      sl;
  ssrx_pkg::ssrx_fmt_t  fmt;
  ssrx_pkg::ssrx_route_t route;

  ssrx_slot_mapper #(.SLOT_BITS(SB)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .bclk(bclk), .fsync(fsync),
    .serial_input(din_a), .second_serial_input(din_b), .dac_word(dac_word),
    .dac_valid(dac_valid)
  );

  ssrx_frame_src #(.SB(SB)) src (.bclk(bclk), .fsync(fsync), .din_a(din_a), .din_b(din_b));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // capture monitor
  always @(posedge clk_sys) begin
    for (int i = 0; i < 3; i++) begin
      if (dac_valid[i] === 1'b1) begin
        cap_cnt[i]++;
        cap_word[i] <= dac_word[i];
      end
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction

  function automatic logic [SB-1:0] exp_word(input ssrx_pkg::ssrx_fmt_t f,
                                             input logic [4:0] s, input logic p);
    logic [4:0] idx;
    // tdm: field is slot; else bit 4 picks right half, slot field minus 16
    idx = (f == ssrx_pkg::FMT_TDM) ? s : (s[4] ? 5'h10 + (s - 5'h10) : s);
    exp_word = p ? wb[idx] : wa[idx];
  endfunction

  task automatic complete_run();
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h00_0000, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0000_0000);
    chk(rd, exp);
    chk(32'(hresp), 32'h0000_0000);
  endtask

  task automatic fill_words();
    for (int s = 0; s < 32; s++) begin
      seed = lfsr(seed);
      wa[s] = seed[15:0];
      wb[s] = seed[31:16];
    end
  endtask

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    seed = 32'h0001_0F4C;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd_chk(ssrx_pkg::IDX_CH2, 32'h0000_0001);
    rd_chk(ssrx_pkg::IDX_CH3, 32'h0000_0002);
    rd_chk(ssrx_pkg::IDX_CH4, 32'h0000_0003);
    rd_chk(ssrx_pkg::IDX_FORMAT, 32'h0000_0000);
    rd_chk(ssrx_pkg::IDX_PIN_SEL, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    xfer(1'b1, ssrx_pkg::IDX_CH2, 32'h0000_00FF);
    rd_chk(ssrx_pkg::IDX_CH2, 32'h0000_003F);
    xfer(1'b1, ssrx_pkg::IDX_CH2, 32'h0000_0001);
    // reset config: all disabled, nothing captured
    fill_words();
    src.send_frame(ssrx_pkg::FMT_TDM, wa, wb);
    repeat (40) @(posedge clk_sys);
    for (int c = 0; c < 3; c++) chk(32'(cap_cnt[c]), 32'h0000_0000);
    for (int it = 0; it < 9; it++) begin
      fmt = ssrx_pkg::ssrx_fmt_t'(it / 3);
      seed = lfsr(seed);
      en = (it % 3 == 2) ? seed[2:0] : 3'h7;
      pin = seed[5:3];
      sl = (it % 3 == 0) ? {5'h10, 5'h1f, 5'h00} : (it % 3 == 1) ? {5'h01, 5'h0f, 5'h0f} :
           seed[20:6];
      xfer(1'b1, ssrx_pkg::IDX_FORMAT, {30'h0000_0000, fmt});
      xfer(1'b1, ssrx_pkg::IDX_PIN_SEL, {28'h000_0000, pin, 1'b0});
      for (int c = 0; c < 3; c++) begin
        route = '{rsv: 2'b00, enable: en[c], slot: sl[c]};
        xfer(1'b1, ssrx_pkg::IDX_CH2 + 8'(c), {24'h00_0000, route});
        prev[c] = cap_cnt[c];
      end
      fill_words();
      src.send_frame(fmt, wa, wb);
      repeat (40) @(posedge clk_sys);
      for (int c = 0; c < 3; c++) begin
        chk(32'(cap_cnt[c]), 32'(prev[c]) + 32'(en[c]));
        if (en[c]) last[c] = exp_word(fmt, sl[c], pin[c]);
        if (en[c]) chk(32'(cap_word[c]), 32'(last[c]));
        rd_chk(ssrx_pkg::IDX_DATA2 + 8'(c), 32'(last[c]));
      end
    end
    xfer(1'b1, ssrx_pkg::IDX_FORMAT, 32'h0000_0003);
    rd_chk(ssrx_pkg::IDX_FORMAT, 32'h0000_0002);
    complete_run();
  end
endmodule
`default_nettype wire
